// *** logic/sfr_top.sv ***
// Status and event flag register with write, clear and set aliases.
//
// Functional notes
// RULE1 - Three aliases share one flag register; 0x000C loads written value.
// RULE2 - Writing ones to 0x0010 clears those flags, others untouched.
// RULE3 - Writing ones to 0x0014 sets those flags, others untouched.
// RULE4 - Reading any alias returns the flag register contents.
// RULE5 - Word, halfword and byte writes act only on selected lanes.
// RULE6 - Mask one: flag tracks source; mask zero: flag latches events.
// RULE7 - Reset mask latches all flags except bits 29 and 22.
// RULE8 - Bit 31 signals a video frame or field stored or fetched.
// RULE9 - Bit 30 reports a host ready-handshake timeout.
// RULE10 - Bit 29 shows direct port writes allowed; host polls it.
// RULE11 - Bit 28 shows direct port access finished, ready again.
// RULE12 - Bits 27..24 report image, copy, access, drawing unit ready.
// RULE13 - Bit 23 flags colour depth mismatch in a memory copy.
// RULE14 - Bit 22 shows command register writable; host polls it.
// RULE15 - Bit 21 latches the external interrupt input.
// RULE16 - Bit 20 marks SDRAM init done, then forced refreshes.
// RULE17 - Bit 19 is driven by graphics sync mixer output six.
// RULE18 - Bit 18 flags a graphics output bandwidth violation.
// RULE19 - Bit 17 flags a command written while not writable.
// RULE20 - Bit 16 flags an invalid command code, run as no-op.
// RULE21 - Bit 15 flags an execution read from an empty FIFO.
// RULE22 - Bits 12..9 report direct port, image, copy, access busy.
// RULE23 - Bits 14 and 13 read zero and ignore all writes.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`include "sfr_consts.svh"
module sfr_top
    import sfr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    input  wire logic        video_frame_event_i,
    input  wire logic        ready_timeout_error_i,
    input  wire logic        direct_port_write_allowed_i,
    input  wire logic        direct_port_done_i,
    input  wire logic [3:0]  unit_ready_i,
    input  wire logic        colour_depth_mismatch_i,
    input  wire logic        command_writable_i,
    input  wire logic        external_irq_i,
    input  wire logic        sdram_init_refresh_i,
    input  wire logic        graphics_sync_event_i,
    input  wire logic        bandwidth_violation_i,
    input  wire logic        command_overflow_error_i,
    input  wire logic        invalid_command_error_i,
    input  wire logic        empty_fifo_read_error_i,
    input  wire logic [3:0]  unit_busy_i,
    output logic [31:0]      flags_o
);
    import sfr_pkg::*;

    // Positions that hold a real flag; a macro cannot be part-selected directly.
    localparam logic [31:0] IMPL_BITS = `SFR_IMPL_BITS;

    logic          ack;
    logic          rd_load;
    logic          commit;
    sfr_wmode_type wmode;
    logic          mask_hit;
    logic          flag_hit;
    logic          irq_meta_q;
    logic          irq_sync_q;
    logic [31:0]   src;
    logic [31:0]   mask_q;
    logic [31:0]   flags;
    logic [31:0]   merged;
    logic          sw_wr_en;
    logic [31:0]   dat_q;

    // The interrupt comes from outside the core, so it is synchronised.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_meta_q <= 1'b0;
            irq_sync_q <= 1'b0;
        end else begin
            irq_meta_q <= external_irq_i;
            irq_sync_q <= irq_meta_q;
        end
    end

    always_comb begin
        src = 32'h0000_0000;
        src[`SFR_BIT_VIDEO]   = video_frame_event_i; // RULE8
        src[`SFR_BIT_READY_TIMEOUT_SETTING]   = ready_timeout_error_i; // RULE9
        src[`SFR_BIT_DPWR]    = direct_port_write_allowed_i; // RULE10
        src[`SFR_BIT_DPDONE]  = direct_port_done_i; // RULE11
        src[`SFR_BIT_READY+:4] = unit_ready_i; // RULE12
        src[`SFR_BIT_DEPTH]   = colour_depth_mismatch_i; // RULE13
        src[`SFR_BIT_CMDWR]   = command_writable_i; // RULE14
        src[`SFR_BIT_EXTIRQ]  = irq_sync_q; // RULE15
        src[`SFR_BIT_SDRAM]   = sdram_init_refresh_i; // RULE16
        src[`SFR_BIT_GRAPHICS_SYNC_EVENT]   = graphics_sync_event_i; // RULE17
        src[`SFR_BIT_BANDWIDTH_VIOLATION]   = bandwidth_violation_i; // RULE18
        src[`SFR_BIT_OVFL]    = command_overflow_error_i; // RULE19
        src[`SFR_BIT_BADCODE] = invalid_command_error_i; // RULE20
        src[`SFR_BIT_EMPTY]   = empty_fifo_read_error_i; // RULE21
        src[`SFR_BIT_BUSY+:4] = unit_busy_i; // RULE22
    end

    sfr_wb_slave u_slave (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cyc_i      (wb_cyc_i),
        .stb_i      (wb_stb_i),
        .we_i       (wb_we_i),
        .adr_i      (wb_adr_i),
        .ack_o      (ack),
        .rd_load_o  (rd_load),
        .commit_o   (commit),
        .wmode_o    (wmode),
        .mask_hit_o (mask_hit),
        .flag_hit_o (flag_hit)
    );

    // Each selected lane gets the method of the addressed alias.
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            logic [7:0] cur;
            logic [7:0] wd;
            logic [7:0] mrg;
            assign cur = flags[lane*8+:8];
            assign wd  = wb_dat_i[lane*8+:8];
            always_comb begin
                mrg = cur;
                if (wb_sel_i[lane]) begin // RULE5
                    unique case (wmode)
                        SFR_WM_DIRECT: mrg = wd; // RULE1
                        SFR_WM_CLEAR:  mrg = cur & ~wd; // RULE2
                        SFR_WM_SET:    mrg = cur | wd; // RULE3
                        SFR_WM_NONE:   mrg = cur;
                    endcase
                end
            end
            // One process per lane owns its slice, so no variable has two writers.
            assign merged[lane*8+:8] = mrg;
        end
    endgenerate

    assign sw_wr_en = commit & flag_hit;

    // Behaviour mask; bits without a flag behind them stay zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `SFR_MASK_RST; // RULE7
        end else if (commit && mask_hit) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    mask_q[b*8+:8] <= wb_dat_i[b*8+:8] & IMPL_BITS[b*8+:8];
                end
            end
        end
    end

    // Only implemented positions get a storage cell.
    genvar fb;
    generate
        for (fb = 0; fb < 32; fb++) begin : g_flag
            if (IMPL_BITS[fb]) begin : g_cell
                sfr_flag_cell u_cell (
                    .clk_i    (clk_i),
                    .rst_i    (rst_i),
                    .src_i    (src[fb]),
                    .track_i  (mask_q[fb]),
                    .wr_en_i  (sw_wr_en),
                    .wr_val_i (merged[fb]),
                    .flag_o   (flags[fb])
                );
            end else begin : g_zero
                assign flags[fb] = 1'b0; // RULE23
            end
        end
    endgenerate

    // Read data is caught as the ack is raised, so it is the value
    // held in the cycle the request was seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (rd_load) begin
            if (flag_hit) begin
                dat_q <= flags; // RULE4
            end else if (mask_hit) begin
                dat_q <= mask_q;
            end else begin
                dat_q <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = dat_q;
    assign flags_o  = flags;

    sequence s_req;
        wb_cyc_i && wb_stb_i && !ack;
    endsequence

    sequence s_answer;
        ack ##1 !ack;
    endsequence

    AST_ACK_TIMING: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_req |=> s_answer)
        else $error("Ack not given for exactly one cycle after request.");

    AST_DIRECT_WRITE: assert property ( // RULE1
        @(posedge clk_i) disable iff (rst_i)
        (commit && wmode == SFR_WM_DIRECT && wb_sel_i == 4'hF)
        |=> (flags & ~$past(mask_q)) ==
            (($past(wb_dat_i) | $past(src)) & `SFR_IMPL_BITS & ~$past(mask_q)))
        else $error("Direct write did not load the flags.");

    AST_CLEAR_WRITE: assert property ( // RULE2
        @(posedge clk_i) disable iff (rst_i)
        (commit && wmode == SFR_WM_CLEAR && wb_sel_i == 4'hF)
        |=> (flags & $past(wb_dat_i) & ~$past(src) & ~$past(mask_q)) == 32'h0000_0000)
        else $error("Clear write left a flag set.");

    AST_SET_WRITE: assert property ( // RULE3
        @(posedge clk_i) disable iff (rst_i)
        (commit && wmode == SFR_WM_SET && wb_sel_i == 4'hF)
        |=> (flags & $past(wb_dat_i) & ~$past(mask_q)) ==
            ($past(wb_dat_i) & `SFR_IMPL_BITS & ~$past(mask_q)))
        else $error("Set write did not set the flags.");

    AST_READ_ALIAS: assert property ( // RULE4
        @(posedge clk_i) disable iff (rst_i)
        (s_req and (flag_hit && !wb_we_i)) |=> ack && wb_dat_o == $past(flags))
        else $error("Alias read returned wrong contents.");

    AST_LANE_KEEP: assert property ( // RULE5
        @(posedge clk_i) disable iff (rst_i)
        (sw_wr_en && !wb_sel_i[3])
        |=> ((flags[31:24] ^ $past(flags[31:24])) & ~$past(mask_q[31:24])
             & ~$past(src[31:24])) == 8'h00)
        else $error("Unselected byte lane changed.");

    AST_TRACKING: assert property ( // RULE6
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (flags & $past(mask_q)) == ($past(src) & $past(mask_q) & `SFR_IMPL_BITS))
        else $error("Tracking flags differ from their sources.");

    AST_MASK_RESET: assert property ( // RULE7
        @(posedge clk_i)
        rst_i |=> mask_q == `SFR_MASK_RST)
        else $error("Behaviour mask wrong after reset.");

    AST_RESERVED_ZERO: assert property ( // RULE23
        @(posedge clk_i) disable iff (rst_i)
        flags_o[14:13] == 2'b00 && mask_q[14:13] == 2'b00)
        else $error("Undefined flag bits are not zero.");

    AST_IRQ_LATCH: assert property ( // RULE15
        @(posedge clk_i) disable iff (rst_i)
        (irq_sync_q && !mask_q[`SFR_BIT_EXTIRQ]) |=> flags[`SFR_BIT_EXTIRQ])
        else $error("External interrupt not latched.");

    // A high source shows in its flag one cycle later whatever the mask says.
    AST_VIDEO_FLAG: assert property ( // RULE8
        @(posedge clk_i) disable iff (rst_i)
        video_frame_event_i |=> flags[`SFR_BIT_VIDEO])
        else $error("Video frame event not flagged.");

    AST_READY_TIMEOUT_SETTING_FLAG: assert property ( // RULE9
        @(posedge clk_i) disable iff (rst_i)
        ready_timeout_error_i |=> flags[`SFR_BIT_READY_TIMEOUT_SETTING])
        else $error("Ready timeout not flagged.");

    AST_DPWR_FLAG: assert property ( // RULE10
        @(posedge clk_i) disable iff (rst_i)
        direct_port_write_allowed_i |=> flags[`SFR_BIT_DPWR])
        else $error("Direct port write permission not flagged.");

    AST_DPWR_DROP: assert property ( // RULE10
        @(posedge clk_i) disable iff (rst_i)
        (!direct_port_write_allowed_i && mask_q[`SFR_BIT_DPWR]) |=> !flags[`SFR_BIT_DPWR])
        else $error("Direct port write permission stayed set.");

    AST_DPDONE_FLAG: assert property ( // RULE11
        @(posedge clk_i) disable iff (rst_i)
        direct_port_done_i |=> flags[`SFR_BIT_DPDONE])
        else $error("Direct port completion not flagged.");

    AST_READY_FLAGS: assert property ( // RULE12
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (flags[`SFR_BIT_READY+:4] & $past(unit_ready_i)) == $past(unit_ready_i))
        else $error("Unit ready not flagged.");

    AST_DEPTH_FLAG: assert property ( // RULE13
        @(posedge clk_i) disable iff (rst_i)
        colour_depth_mismatch_i |=> flags[`SFR_BIT_DEPTH])
        else $error("Colour depth mismatch not flagged.");

    AST_CMDWR_FLAG: assert property ( // RULE14
        @(posedge clk_i) disable iff (rst_i)
        command_writable_i |=> flags[`SFR_BIT_CMDWR])
        else $error("Command writable not flagged.");

    AST_CMDWR_DROP: assert property ( // RULE14
        @(posedge clk_i) disable iff (rst_i)
        (!command_writable_i && mask_q[`SFR_BIT_CMDWR]) |=> !flags[`SFR_BIT_CMDWR])
        else $error("Command writable stayed set.");

    AST_SDRAM_FLAG: assert property ( // RULE16
        @(posedge clk_i) disable iff (rst_i)
        sdram_init_refresh_i |=> flags[`SFR_BIT_SDRAM])
        else $error("SDRAM init or refresh not flagged.");

    AST_GRAPHICS_SYNC_EVENT_FLAG: assert property ( // RULE17
        @(posedge clk_i) disable iff (rst_i)
        graphics_sync_event_i |=> flags[`SFR_BIT_GRAPHICS_SYNC_EVENT])
        else $error("Graphics sync event not flagged.");

    AST_BANDWIDTH_VIOLATION_FLAG: assert property ( // RULE18
        @(posedge clk_i) disable iff (rst_i)
        bandwidth_violation_i |=> flags[`SFR_BIT_BANDWIDTH_VIOLATION])
        else $error("Bandwidth violation not flagged.");

    AST_OVFL_FLAG: assert property ( // RULE19
        @(posedge clk_i) disable iff (rst_i)
        command_overflow_error_i |=> flags[`SFR_BIT_OVFL])
        else $error("Command overflow not flagged.");

    AST_BADCODE_FLAG: assert property ( // RULE20
        @(posedge clk_i) disable iff (rst_i)
        invalid_command_error_i |=> flags[`SFR_BIT_BADCODE])
        else $error("Invalid command code not flagged.");

    AST_EMPTY_FLAG: assert property ( // RULE21
        @(posedge clk_i) disable iff (rst_i)
        empty_fifo_read_error_i |=> flags[`SFR_BIT_EMPTY])
        else $error("Empty FIFO read not flagged.");

    AST_BUSY_FLAGS: assert property ( // RULE22
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (flags[`SFR_BIT_BUSY+:4] & $past(unit_busy_i)) == $past(unit_busy_i))
        else $error("Unit busy not flagged.");
endmodule

// *** logic/sfr_consts.svh ***
// Offsets, bit positions, reset values of the status flag register.
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH
`define SFR_OFS_DIRECT   16'h000C
`define SFR_OFS_CLEAR    16'h0010
`define SFR_OFS_SET      16'h0014
`define SFR_OFS_MASK     16'h0018
`define SFR_IMPL_BITS    32'hFFFF_9E00
`define SFR_MASK_RST     32'h2040_0000
`define SFR_FLAG_RST     1'b0
`define SFR_BIT_VIDEO    31
`define SFR_BIT_READY_TIMEOUT_SETTING    30
`define SFR_BIT_DPWR     29
`define SFR_BIT_DPDONE   28
`define SFR_BIT_READY    24
`define SFR_BIT_DEPTH    23
`define SFR_BIT_CMDWR    22
`define SFR_BIT_EXTIRQ   21
`define SFR_BIT_SDRAM    20
`define SFR_BIT_GRAPHICS_SYNC_EVENT    19
`define SFR_BIT_BANDWIDTH_VIOLATION    18
`define SFR_BIT_OVFL     17
`define SFR_BIT_BADCODE  16
`define SFR_BIT_EMPTY    15
`define SFR_BIT_BUSY     9
`endif

// *** logic/sfr_pkg.sv ***
// Types shared by the status flag register files.
package sfr_pkg;
    typedef enum logic [1:0] {
        SFR_WM_NONE   = 2'b00,
        SFR_WM_DIRECT = 2'b01,
        SFR_WM_CLEAR  = 2'b10,
        SFR_WM_SET    = 2'b11
    } sfr_wmode_type;
endpackage

// *** logic/sfr_wb_slave.sv ***
// Wishbone classic slave decode for the flag register aliases.
`timescale 1ns/1ps
`include "sfr_consts.svh"
module sfr_wb_slave
    import sfr_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [15:0]           adr_i,
    output logic                       ack_o,
    output logic                       rd_load_o,
    output logic                       commit_o,
    output sfr_pkg::sfr_wmode_type     wmode_o,
    output logic                       mask_hit_o,
    output logic                       flag_hit_o
);
    logic ack_q;

    // Ack comes one cycle after the request and drops the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    always_comb begin
        wmode_o = SFR_WM_NONE;
        unique case (adr_i)
            `SFR_OFS_DIRECT: wmode_o = SFR_WM_DIRECT;
            `SFR_OFS_CLEAR:  wmode_o = SFR_WM_CLEAR;
            `SFR_OFS_SET:    wmode_o = SFR_WM_SET;
            default:         wmode_o = SFR_WM_NONE;
        endcase
    end

    assign ack_o      = ack_q;
    assign rd_load_o  = cyc_i & stb_i & ~ack_q;
    assign commit_o   = cyc_i & stb_i & we_i & ack_q;
    assign mask_hit_o = (adr_i == `SFR_OFS_MASK);
    assign flag_hit_o = (wmode_o != SFR_WM_NONE);
endmodule

// *** logic/sfr_flag_cell.sv ***
// One status flag with tracking or latching behaviour.
`timescale 1ns/1ps
`include "sfr_consts.svh"
module sfr_flag_cell (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic src_i,
    input  wire logic track_i,
    input  wire logic wr_en_i,
    input  wire logic wr_val_i,
    output logic      flag_o
);
    // A latched event beats a software clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= `SFR_FLAG_RST;
        end else if (track_i) begin
            flag_o <= src_i; // RULE6
        end else if (src_i) begin
            flag_o <= 1'b1; // RULE6
        end else if (wr_en_i) begin
            flag_o <= wr_val_i;
        end
    end

    AST_TRACK_FOLLOWS: assert property ( // RULE6
        @(posedge clk_i) disable iff (rst_i)
        track_i |=> flag_o == $past(src_i))
        else $error("Tracking flag does not follow its source.");

    AST_LATCH_HOLDS: assert property ( // RULE6
        @(posedge clk_i) disable iff (rst_i)
        (!track_i && flag_o && !wr_en_i) |=> flag_o)
        else $error("Latched flag dropped without software clear.");
endmodule

// *** dv/sfr_host_model.sv ***
// Host model issuing classic Wishbone single cycles to the flag register.
`timescale 1ns/1ps
module sfr_host_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [15:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 16'h0000;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    // The request is held until ack is sampled, so a slow answer is tolerated.
    task automatic xfer(input logic w, input logic [15:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) begin
            @(posedge clk_i);
        end
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        // Released address and data lines carry inverted values so stale data cannot look valid.
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the status flag register.
`timescale 1ns/1ps
module tb;
    import sfr_pkg::*;
    typedef struct {
        logic [15:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
        logic [31:0] exp;
    } sfr_row_type;

    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] flags_o;
    logic [31:0] src;
    int          n_fail = 0;
    int          n_checks = 0;

    sfr_row_type rows [10] = '{
        '{16'h000C, 4'hF, 32'hFFFF_FFFF, 32'hDFBF_9E00},
        '{16'h0010, 4'h2, 32'hFFFF_FFFF, 32'hDFBF_0000},
        '{16'h0010, 4'h4, 32'hFFFF_FFFF, 32'hDF00_0000},
        '{16'h0014, 4'h2, 32'h0000_FF00, 32'hDF00_9E00},
        '{16'h000C, 4'h3, 32'h0000_0000, 32'hDF00_0000},
        '{16'h0014, 4'h8, 32'h0000_0000, 32'hDF00_0000},
        '{16'h000C, 4'hC, 32'h0000_0000, 32'h0000_0000},
        '{16'h0014, 4'hF, 32'hFFFF_FFFF, 32'hDFBF_9E00},
        '{16'h0010, 4'h8, 32'hFFFF_FFFF, 32'h00BF_9E00},
        '{16'h0010, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}
    };

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    sfr_host_model host (
        .clk_i (clk_i),
        .ack_i (ack),
        .dat_i (rdat),
        .cyc_o (cyc),
        .stb_o (stb),
        .we_o  (we),
        .adr_o (adr),
        .sel_o (sel),
        .dat_o (wdat)
    );

    sfr_top dut (
        .clk_i                       (clk_i),
        .rst_i                       (rst_i),
        .wb_cyc_i                    (cyc),
        .wb_stb_i                    (stb),
        .wb_we_i                     (we),
        .wb_adr_i                    (adr),
        .wb_sel_i                    (sel),
        .wb_dat_i                    (wdat),
        .wb_ack_o                    (ack),
        .wb_dat_o                    (rdat),
        .video_frame_event_i         (src[31]),
        .ready_timeout_error_i       (src[30]),
        .direct_port_write_allowed_i (src[29]),
        .direct_port_done_i          (src[28]),
        .unit_ready_i                (src[27:24]),
        .colour_depth_mismatch_i     (src[23]),
        .command_writable_i          (src[22]),
        .external_irq_i              (src[21]),
        .sdram_init_refresh_i        (src[20]),
        .graphics_sync_event_i       (src[19]),
        .bandwidth_violation_i       (src[18]),
        .command_overflow_error_i    (src[17]),
        .invalid_command_error_i     (src[16]),
        .empty_fifo_read_error_i     (src[15]),
        .unit_busy_i                 (src[12:9]),
        .flags_o                     (flags_o)
    );

    task automatic end_of_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, s, d, q);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host.xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
        chk(q, exp);
    endtask

    // Sources change one edge after this call and are seen by the next edges.
    task automatic drive_src(input logic [31:0] v, input int wait_n);
        @(posedge clk_i);
        src <= v;
        repeat (wait_n) @(posedge clk_i);
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        src   = 32'h0000_0000;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].sel, rows[i].dat);
            rd_chk(rows[i].adr, rows[i].exp);
            chk(flags_o, rows[i].exp);
        end
        // Tracking flags ignore a clear while their source is high.
        drive_src(32'h2040_0000, 2);
        wr(16'h0010, 4'hF, 32'hFFFF_FFFF);
        rd_chk(16'h0014, 32'h2040_0000);
        drive_src(32'h0000_0000, 2);
        rd_chk(16'h000C, 32'h0000_0000);
        // One-cycle events must stay latched after the sources drop.
        drive_src(32'hDFBF_9E00, 0);
        drive_src(32'h0000_0000, 4);
        rd_chk(16'h0010, 32'hDFBF_9E00);
        chk(flags_o, 32'hDFBF_9E00);
        // A reset in mid-run clears flags and restores the behaviour mask.
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(16'h000C, 32'h0000_0000);
        rd_chk(16'h0018, 32'h2040_0000);
        drive_src(32'h8000_0000, 0);
        drive_src(32'h0000_0000, 3);
        rd_chk(16'h000C, 32'h8000_0000);
        // With every mask bit one, all flags follow their sources.
        wr(16'h0018, 4'hF, 32'hFFFF_FFFF);
        drive_src(32'hFFFF_FFFF, 4);
        rd_chk(16'h000C, 32'hFFFF_9E00);
        drive_src(32'h0000_0000, 4);
        rd_chk(16'h000C, 32'h0000_0000);
        rd_chk(16'h0020, 32'h0000_0000);
        end_of_test();
    end
endmodule
